/* File: design/kwd_pkg.sv */
// Constants and types shared by the keyed watchdog design
package kwd_pkg;
    // Register map, byte addresses on the register port
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_KEY = 8'h04;
    // Feed-key bytes, in the order they must arrive
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'h5a;
    // Control field positions
    localparam int BIT_RST_FLAG = 31;
    localparam int BIT_RST_EN = 11;
    localparam int BIT_INT_EN = 10;
    localparam int BIT_INT_FLAG = 9;
    localparam int BIT_WDT_EN = 8;
    localparam int RST_PER_LSB = 4;
    localparam int INT_PER_LSB = 0;
    localparam int PER_W = 4;
    localparam int KEY_W = 8;
    // Timeout is two to the power of (base minus field value) cycles
    localparam logic [4:0] PERIOD_BASE = 5'h1f;
    // Reset values
    localparam logic [PER_W-1:0] PER_RST = 4'h0;
    localparam logic [KEY_W-1:0] KEY_RST = 8'h00;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;

    // Progress through the two-write key order
    typedef enum logic [1:0] {
        KWD_KEY_IDLE = 2'b00,
        KWD_KEY_GOT_FIRST = 2'b01,
        KWD_KEY_ARMED = 2'b10
    } kwd_key_t;
endpackage

/* File: design/kwd_cnt_if.sv */
// Link between the register front end and the watchdog counter
`timescale 1ns/1ps
interface kwd_cnt_if;
    logic restart;
    logic run;
    logic [3:0] int_sel;
    logic [3:0] rst_sel;
    logic int_hit;
    logic rst_hit;
    modport ctl (output restart, output run, output int_sel, output rst_sel, input int_hit, input rst_hit);
    modport cnt (input restart, input run, input int_sel, input rst_sel, output int_hit, output rst_hit);
endinterface

/* File: design/kwd_counter.sv */
// Watchdog up-counter with the two power-of-two timeout compares
`timescale 1ns/1ps
module kwd_counter
    import kwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    kwd_cnt_if.cnt cif
);
    logic [31:0] count;
    logic [4:0] int_shift;
    logic [4:0] rst_shift;
    logic [31:0] int_last;
    logic [31:0] rst_last;

    // Last count value before each timeout, 2^(31-sel) cycles after restart
    assign int_shift = 5'(PERIOD_BASE - {1'b0, cif.int_sel});
    assign rst_shift = 5'(PERIOD_BASE - {1'b0, cif.rst_sel});
    assign int_last = (32'h0000_0001 << int_shift) - 32'h0000_0001;
    assign rst_last = (32'h0000_0001 << rst_shift) - 32'h0000_0001;

    // Hits are one-cycle pulses since the count moves on right after
    assign cif.int_hit = cif.run && !cif.restart && (count == int_last);
    assign cif.rst_hit = cif.run && !cif.restart && (count == rst_last);

    // Free-running count; wraps after 2^32 so a disabled reset path can fire again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= CNT_RST;
        end else if (cif.restart) begin
            count <= CNT_RST;
        end else if (cif.run) begin
            count <= count + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    restart_clears_a: assert property (cif.restart |=> count == CNT_RST)
        else $error("counter not cleared by restart");
    count_steps_a: assert property (cif.run && !cif.restart |=> count == $past(count) + 32'h0000_0001)
        else $error("counter did not advance by one");
    idle_holds_a: assert property (!cif.run |=> count == CNT_RST || $stable(count))
        else $error("counter moved while stopped");
endmodule

/* File: design/kwd_top.sv */
// Keyed watchdog timer: register front end, key sequencer and reset request
`timescale 1ns/1ps
// Operation
// - Enabling needs key A5 then 5A, then writing the on bit as one.
// - Clearing the on bit stops the watchdog; no interrupt and no reset follow.
// - Power-on reset clears the on bit, so the watchdog starts disabled.
// - Other resets, watchdog reset included, keep the on bit as it was.
// - Key A5 then 5A restarts the counter before either timeout.
// - Bit 31 flags a reset caused by the watchdog; software may also write it either way.
// - Bit 11 enables the system reset on expiry; only power-on or a software write clears it.
// - Bit 10 gates the interrupt request; resets to zero.
// - Bit 9 is set on interrupt expiry, raises request if enabled, write one clears.
// - On bit is control bit 8, reset zero, cleared only at power-on or by software.
// - Bits 7:4 give reset timeout of 2^(31-value) clock cycles.
// - Bits 3:0 give interrupt timeout with the same power-of-two coding.
// - Key register takes bytes in 7:0; bits 31:8 read zero.
// - Every reset returns the counter to its starting value.
module kwd_top
    import kwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    output logic wdt_reset_req
);
    kwd_cnt_if cif ();

    logic wdt_en;
    logic rst_en;
    logic int_en;
    logic int_flag;
    logic rst_flag;
    logic [PER_W-1:0] rst_per;
    logic [PER_W-1:0] int_per;
    logic [KEY_W-1:0] key_last;
    kwd_key_t key_state;
    kwd_key_t next_key_state;
    logic ctrl_wr;
    logic key_wr;
    logic key_ok;
    logic [31:0] next_rdata;

    kwd_counter u_counter (
        .clk(clk),
        .rst(rst),
        .cif(cif)
    );

    // Register writes are ignored while a system reset holds the block
    always_comb begin
        ctrl_wr = 1'b0;
        key_wr = 1'b0;
        if (wr && !sys_rst && addr == OFS_CTRL) begin
            ctrl_wr = 1'b1;
        end else if (wr && !sys_rst && addr == OFS_KEY) begin
            key_wr = 1'b1;
        end
    end

    // Second key completes the order only right after a first key
    assign key_ok = key_wr && key_state == KWD_KEY_GOT_FIRST && wdata[KEY_W-1:0] == KEY_SECOND;

    // Key order tracker; any other byte drops back to idle
    always_comb begin
        next_key_state = key_state;
        if (sys_rst) begin
            next_key_state = KWD_KEY_IDLE;
        end else if (key_wr) begin
            if (wdata[KEY_W-1:0] == KEY_FIRST) begin
                next_key_state = KWD_KEY_GOT_FIRST;
            end else if (key_ok) begin
                next_key_state = KWD_KEY_ARMED;
            end else begin
                next_key_state = KWD_KEY_IDLE;
            end
        end else if (ctrl_wr && wdata[BIT_WDT_EN]) begin
            // Arming is spent by the enabling write
            next_key_state = KWD_KEY_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_state <= KWD_KEY_IDLE;
        end else begin
            key_state <= next_key_state;
        end
    end

    // On bit: set only when armed, cleared by software or power-on only
    // A write of one without arming leaves the bit as it was, so a stray write cannot start it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_en <= 1'b0;
        end else if (ctrl_wr) begin
            if (!wdata[BIT_WDT_EN]) begin
                wdt_en <= 1'b0;
            end else if (key_state == KWD_KEY_ARMED) begin
                wdt_en <= 1'b1;
            end
        end
    end

    // Reset enable survives system resets, only power-on or a software write clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_en <= 1'b0;
        end else if (ctrl_wr) begin
            rst_en <= wdata[BIT_RST_EN];
        end
    end

    // Plain settings return to reset values on any reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_en <= 1'b0;
            rst_per <= PER_RST;
            int_per <= PER_RST;
        end else if (sys_rst) begin
            int_en <= 1'b0;
            rst_per <= PER_RST;
            int_per <= PER_RST;
        end else if (ctrl_wr) begin
            int_en <= wdata[BIT_INT_EN];
            rst_per <= wdata[RST_PER_LSB +: PER_W];
            int_per <= wdata[INT_PER_LSB +: PER_W];
        end
    end

    // Key byte holds what was last written, readable back
    // Cleared by any reset so a stale byte never reads back after a restart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_last <= KEY_RST;
        end else if (sys_rst) begin
            key_last <= KEY_RST;
        end else if (key_wr) begin
            key_last <= wdata[KEY_W-1:0];
        end
    end

    // Interrupt flag: a hit in the clearing cycle wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_flag <= 1'b0;
        end else if (cif.int_hit) begin
            int_flag <= 1'b1;
        end else if (sys_rst) begin
            int_flag <= 1'b0;
        end else if (ctrl_wr && wdata[BIT_INT_FLAG]) begin
            int_flag <= 1'b0;
        end
    end

    // Cause flag must outlive the reset it requested, so sys_rst leaves it
    // Software may write the flag either way; a hit in the same cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_flag <= 1'b0;
        end else if (cif.rst_hit && rst_en) begin
            rst_flag <= 1'b1;
        end else if (ctrl_wr) begin
            rst_flag <= wdata[BIT_RST_FLAG];
        end
    end

    // System reset request, one cycle per expiry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= cif.rst_hit && rst_en;
        end
    end

    // Registered interrupt request gated by the enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= int_flag && int_en;
        end
    end

    // Counter control; a stopped watchdog is held at its start value
    // Holding at zero while off means a re-enable always starts a full period
    assign cif.restart = key_ok || sys_rst || !wdt_en;
    assign cif.run = wdt_en;
    assign cif.int_sel = int_per;
    assign cif.rst_sel = rst_per;

    // Read mux; unmapped addresses read zero
    // Reserved control bits 30:12 are never driven, so they read zero too
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd && addr == OFS_CTRL) begin
            next_rdata[BIT_RST_FLAG] = rst_flag;
            next_rdata[BIT_RST_EN] = rst_en;
            next_rdata[BIT_INT_EN] = int_en;
            next_rdata[BIT_INT_FLAG] = int_flag;
            next_rdata[BIT_WDT_EN] = wdt_en;
            next_rdata[RST_PER_LSB +: PER_W] = rst_per;
            next_rdata[INT_PER_LSB +: PER_W] = int_per;
        end else if (rd && addr == OFS_KEY) begin
            next_rdata[KEY_W-1:0] = key_last;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Key order steps as the bus presents them
    sequence first_key_s;
        key_wr && wdata[KEY_W-1:0] == KEY_FIRST;
    endsequence

    sequence second_key_s;
        key_wr && wdata[KEY_W-1:0] == KEY_SECOND;
    endsequence

    sequence arm_write_s;
        ctrl_wr && wdata[BIT_WDT_EN];
    endsequence

    sequence int_expiry_s;
        cif.int_hit ##1 int_en;
    endsequence

    // Key order and enabling
    key_feed_restart_a: assert property (first_key_s ##1 second_key_s |-> cif.restart)
        else $error("key order did not restart the counter");
    key_order_arm_a: assert property (first_key_s ##1 second_key_s ##1 arm_write_s |=> wdt_en)
        else $error("protected order did not enable the watchdog");
    enable_guard_a: assert property ($rose(wdt_en) |-> $past(key_state) == KWD_KEY_ARMED && $past(ctrl_wr))
        else $error("watchdog enabled without the key order");
    bad_order_a: assert property (key_wr && key_state != KWD_KEY_GOT_FIRST |-> !key_ok ##1 key_state != KWD_KEY_ARMED)
        else $error("out-of-order key was accepted");
    arm_spent_a: assert property (arm_write_s |=> key_state == KWD_KEY_IDLE)
        else $error("arming not consumed by the enabling write");
    stray_key_a: assert property (key_wr && wdata[KEY_W-1:0] != KEY_FIRST && wdata[KEY_W-1:0] != KEY_SECOND |->
        (!wdt_en || !cif.restart) ##1 key_state == KWD_KEY_IDLE)
        else $error("stray key byte restarted or kept the order");
    sys_rst_key_a: assert property (sys_rst |=> key_state == KWD_KEY_IDLE)
        else $error("half-entered key order survived a system reset");

    // Stopping and resets
    manual_off_a: assert property (ctrl_wr && !wdata[BIT_WDT_EN] |=> !wdt_en ##1 !wdt_reset_req && !cif.int_hit)
        else $error("watchdog still active after disable");
    stopped_quiet_a: assert property (!wdt_en |-> !cif.int_hit && !cif.rst_hit)
        else $error("timeout while watchdog off");
    sys_rst_keep_a: assert property (sys_rst |=> wdt_en == $past(wdt_en) && rst_en == $past(rst_en))
        else $error("system reset changed a power-on-only bit");
    sys_rst_clear_a: assert property (sys_rst |-> cif.restart ##1 !int_en)
        else $error("system reset did not clear counter or settings");
    wdt_en_hold_a: assert property (!ctrl_wr |=> wdt_en == $past(wdt_en))
        else $error("on bit changed without a control write");
    rst_en_hold_a: assert property (!ctrl_wr |=> rst_en == $past(rst_en))
        else $error("reset enable changed without a control write");
    rst_flag_hold_a: assert property (
        !ctrl_wr && !(cif.rst_hit && rst_en) |=> rst_flag == $past(rst_flag))
        else $error("cause flag changed without an expiry or a write");

    // Expiry, flags and requests
    reset_expiry_a: assert property (cif.rst_hit && rst_en |=> wdt_reset_req && rst_flag ##1 !wdt_reset_req)
        else $error("reset expiry not requested and flagged");
    no_reset_off_a: assert property (!rst_en |=> !wdt_reset_req)
        else $error("reset requested while disabled");
    int_flag_set_a: assert property (cif.int_hit |=> int_flag)
        else $error("interrupt expiry did not set the flag");
    int_request_a: assert property (int_flag && int_en |=> irq)
        else $error("pending enabled interrupt not raised");
    int_gated_a: assert property (!int_en |=> !irq)
        else $error("interrupt raised while gated");
    w1c_clear_a: assert property (ctrl_wr && wdata[BIT_INT_FLAG] && !cif.int_hit |=> !int_flag)
        else $error("write one did not clear the flag");
    int_chain_a: assert property (int_expiry_s |=> irq)
        else $error("interrupt expiry did not reach the request");

    // Read side and settings
    key_read_a: assert property (rd && addr == OFS_KEY |=> rdata[31:KEY_W] == 24'h000000)
        else $error("key register upper bits not zero");
    period_load_a: assert property (ctrl_wr |=>
        rst_per == $past(wdata[RST_PER_LSB +: PER_W]) && int_per == $past(wdata[INT_PER_LSB +: PER_W]))
        else $error("period fields not loaded");
endmodule

/* File: bench/kwd_top_tb.sv */
// Self-checking bench for the keyed watchdog top level
`timescale 1ns/1ps
module kwd_top_tb;
    import kwd_pkg::*;
    logic clk;
    logic rst;
    logic sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic irq;
    logic wdt_reset_req;
    int fail_count = 0;
    int checks = 0;
    logic [31:0] v;
    int n;

    kwd_top uut (.clk(clk), .rst(rst), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .wdt_reset_req(wdt_reset_req));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Values compared as four-state, so an unknown never matches
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Both key bytes on back-to-back strobes, then at once the control write if asked
    task automatic key_seq(input logic [31:0] second, input logic arm, input logic [31:0] ctrl);
        @(posedge clk);
        wr <= 1'b1;
        addr <= OFS_KEY;
        wdata <= 32'h0000_00a5;
        @(posedge clk);
        wdata <= second;
        @(posedge clk);
        if (arm) begin
            addr <= OFS_CTRL;
            wdata <= ctrl;
            @(posedge clk);
        end
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic t_reset();
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h0000_0000, v);
        rd_reg(OFS_KEY, v);
        chk("key", 32'h0000_0000, v);
        rd_reg(8'h08, v);
        chk("unmapped", 32'h0000_0000, v);
        $display("test reset values done");
    endtask

    // Enabling without the key order must be refused
    task automatic t_refuse();
        wr_reg(OFS_CTRL, 32'h0000_0dff);
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h0000_0cff, v);
        wr_reg(OFS_KEY, 32'h0000_00a5);
        wr_reg(OFS_KEY, 32'h0000_0000);
        wr_reg(OFS_KEY, 32'h0000_005a);
        wr_reg(OFS_CTRL, 32'h0000_0dff);
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h0000_0cff, v);
        $display("test refused enable done");
    endtask

    // Shortest periods: interrupt and reset both at 2^16 cycles after a feed
    task automatic t_timeout();
        key_seq(32'hffff_ff5a, 1'b1, 32'h0000_0dff);
        rd_reg(OFS_KEY, v);
        chk("key", 32'h0000_005a, v);
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h0000_0dff, v);
        repeat (100) @(posedge clk);
        key_seq(32'h0000_005a, 1'b0, 32'h0000_0000);
        n = 0;
        #1;
        while (wdt_reset_req !== 1'b1 && n < 70000) begin
            @(posedge clk);
            #1;
            n++;
        end
        // Request is registered, so it lands 2^16 edges after the restart edge
        chk("delay", 32'h0001_0000, 32'(n));
        // Equal periods: the interrupt trails the reset instead of warning ahead of it
        chk("irq_early", 32'h0, {31'h0, irq});
        @(posedge clk);
        #1;
        chk("req_pulse", 32'h0, {31'h0, wdt_reset_req});
        chk("irq_next", 32'h1, {31'h0, irq});
        @(posedge clk);
        #1;
        chk("irq", 32'h1, {31'h0, irq});
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h8000_0fff, v);
        wr_reg(OFS_CTRL, 32'h8000_0fff);
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h8000_0dff, v);
        @(posedge clk);
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        $display("test timeout done");
    endtask

    // Other resets keep the on bit, reset enable and cause flag
    task automatic t_resets();
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h8000_0900, v);
        wr_reg(OFS_CTRL, 32'h8000_0800);
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h8000_0800, v);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFS_CTRL, v);
        chk("ctrl", 32'h0000_0000, v);
        $display("test resets done");
    endtask

    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, well beyond the longest expected run
    initial begin
        #(100 * 80000);
        fail_count++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        sys_rst = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_refuse();
        t_timeout();
        t_resets();
        complete_run();
    end
endmodule
